// ==== tmrov_top.sv ====
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "tmrov_consts.svh"

module tmrov_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External count pin
  input wire logic external_count_input,
  // Interrupt requests
  output logic irq,
  output logic irq_high,
  output logic irq_low
);

  localparam logic [7:0] INSTR_LAST = 8'(`TMROV_INSTR_CYCLES - 1);

  tmrov_pkg::tmrov_state_t s;
  tmrov_pkg::tmrov_state_t next_s;

  logic setup;
  logic access;
  logic wr;
  logic instr_tick;
  logic ext_edge;
  logic src_event;
  logic step;
  logic ovf;
  logic wide;
  logic [7:0] ps_limit;
  logic [7:0] addr;

  always_comb begin
    next_s = s;
    addr = 8'(paddr);
    setup = psel & ~penable;
    access = psel & penable & s.pready;
    wr = access & pwrite;
    wide = ~s.ctrl[`TMROV_CTRL_BYTE_WIDTH];
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;

    // Instruction clock from the core clock
    instr_tick = (s.div_cnt == INSTR_LAST);
    if (instr_tick) begin
      next_s.div_cnt = 8'h00;
    end else begin
      next_s.div_cnt = s.div_cnt + 8'h01;
    end

    // Pin passes two flops before the edge detector, adding one more stage
    next_s.ext_s2 = s.ext_s1;
    next_s.ext_s3 = s.ext_s2;
    next_s.ext_s1 = external_count_input;
    if (s.ctrl[`TMROV_CTRL_EDGE]) begin
      ext_edge = s.ext_s3 & ~s.ext_s2;
    end else begin
      ext_edge = ~s.ext_s3 & s.ext_s2;
    end

    if (s.ctrl[`TMROV_CTRL_SRC]) begin
      src_event = ext_edge;
    end else begin
      src_event = instr_tick;
    end

    // Hold-off counts down in instruction cycles
    if (instr_tick && s.holdoff != 2'h0) begin
      next_s.holdoff = s.holdoff - 2'h1;
    end

    // Prescale ratio 2, 4 ... 256
    ps_limit = 8'((16'h0002 << s.ctrl[`TMROV_CTRL_PS_MSB:0]) - 16'h0001);
    step = 1'b0;
    if (s.ctrl[`TMROV_CTRL_RUN] && src_event && s.holdoff == 2'h0) begin
      if (s.ctrl[`TMROV_CTRL_PS_BYPASS]) begin
        step = 1'b1;
      end else if (s.pre_cnt == ps_limit) begin
        next_s.pre_cnt = 8'h00;
        step = 1'b1;
      end else begin
        next_s.pre_cnt = s.pre_cnt + 8'h01;
      end
    end

    ovf = 1'b0;
    if (step) begin
      if (wide) begin
        next_s.count = s.count + 16'h0001;
        ovf = (s.count == 16'hFFFF);
      end else begin
        next_s.count = {s.count[15:8], s.count[7:0] + 8'h01};
        ovf = (s.count[7:0] == 8'hFF);
      end
    end

    // Setup phase: decode, capture read data, answer in the next cycle
    if (setup) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (addr)
          `TMROV_ADDR_CTRL: begin
            next_s.prdata = {24'h00_0000, s.ctrl};
          end
          `TMROV_ADDR_LOW: begin
            next_s.prdata = {24'h00_0000, next_s.count[7:0]};
            // Copy taken with the low byte so both halves match
            if (wide) begin
              next_s.hbuf = next_s.count[15:8];
            end
          end
          `TMROV_ADDR_HBUF: begin
            next_s.prdata = {24'h00_0000, s.hbuf};
          end
          `TMROV_ADDR_INTC: begin
            next_s.prdata[`TMROV_INTC_IE] = s.ie;
            next_s.prdata[`TMROV_INTC_FLAG] = s.flag;
          end
          `TMROV_ADDR_INTC2: begin
            next_s.prdata[`TMROV_INTC2_PRIO] = s.prio;
          end
          default: begin
            next_s.pslverr = 1'b1;
          end
        endcase
      end else begin
        unique case (addr)
          `TMROV_ADDR_CTRL, `TMROV_ADDR_LOW, `TMROV_ADDR_HBUF,
          `TMROV_ADDR_INTC, `TMROV_ADDR_INTC2: begin
            next_s.pslverr = 1'b0;
          end
          default: begin
            next_s.pslverr = 1'b1;
          end
        endcase
      end
    end

    // Sticky flag; a new overflow wins over a write-one clear
    if (wr && addr == `TMROV_ADDR_INTC && pwdata[`TMROV_INTC_FLAG]) begin
      next_s.flag = 1'b0;
    end
    if (ovf) begin
      next_s.flag = 1'b1;
    end

    // Access phase: writes take effect
    if (wr) begin
      unique case (addr)
        `TMROV_ADDR_CTRL: begin
          next_s.ctrl = pwdata[7:0];
        end
        `TMROV_ADDR_LOW: begin
          next_s.count[7:0] = pwdata[7:0];
          if (wide) begin
            next_s.count[15:8] = s.hbuf;
          end
          next_s.pre_cnt = 8'h00;
          next_s.holdoff = `TMROV_HOLDOFF_INSTR;
        end
        `TMROV_ADDR_HBUF: begin
          // Only the buffer moves; the real high byte waits for the low write, and in byte-width mode that write does not load it
          next_s.hbuf = pwdata[7:0];
        end
        `TMROV_ADDR_INTC: begin
          next_s.ie = pwdata[`TMROV_INTC_IE];
        end
        `TMROV_ADDR_INTC2: begin
          next_s.prio = pwdata[`TMROV_INTC2_PRIO];
        end
        default: begin
          next_s.ie = s.ie;
        end
      endcase
    end

    // Interrupt outputs registered from the updated state
    next_s.irq = next_s.flag & next_s.ie;
    next_s.irq_high = next_s.irq & next_s.prio;
    next_s.irq_low = next_s.irq & ~next_s.prio;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl <= `TMROV_CTRL_RESET;
      s.count <= `TMROV_CNT_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign irq_high = s.irq_high;
  assign irq_low = s.irq_low;

endmodule : tmrov_top
`default_nettype wire

// ==== tmrov_consts.svh ====
`ifndef TMROV_CONSTS_SVH
`define TMROV_CONSTS_SVH

// Register byte addresses
`define TMROV_ADDR_CTRL 8'h00
`define TMROV_ADDR_LOW 8'h04
`define TMROV_ADDR_HBUF 8'h08
`define TMROV_ADDR_INTC 8'h0C
`define TMROV_ADDR_INTC2 8'h10

// timer_control fields
`define TMROV_CTRL_RUN 7
`define TMROV_CTRL_BYTE_WIDTH 6
`define TMROV_CTRL_SRC 5
`define TMROV_CTRL_EDGE 4
`define TMROV_CTRL_PS_BYPASS 3
`define TMROV_CTRL_PS_MSB 2

// interrupt_control and interrupt_control_two fields
`define TMROV_INTC_IE 5
`define TMROV_INTC_FLAG 2
`define TMROV_INTC2_PRIO 2

// Reset values
`define TMROV_CTRL_RESET 8'hC8
`define TMROV_CNT_RESET 16'h0000

// Timing: instruction cycle is 40 ns, write hold-off is two instruction cycles
`define TMROV_INSTR_NS 40
`define TMROV_CLK_NS 10
`define TMROV_INSTR_CYCLES (`TMROV_INSTR_NS / `TMROV_CLK_NS)
`define TMROV_HOLDOFF_INSTR 2'h2

`endif

// ==== tmrov_pkg.sv ====
`default_nettype none
package tmrov_pkg;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] count;
    logic [7:0] hbuf;
    logic ie;
    logic flag;
    logic prio;
    logic [7:0] pre_cnt;
    logic [7:0] div_cnt;
    logic [1:0] holdoff;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic irq_high;
    logic irq_low;
  } tmrov_state_t;

endpackage : tmrov_pkg
`default_nettype wire

// ==== tmrov_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module tmrov_sva #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin and interrupts
  input wire logic external_count_input,
  input wire logic irq,
  input wire logic irq_high,
  input wire logic irq_low
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready held too long");
  property p_rdy_setup; psel && !penable |=> pready; endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("pready late");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_unmap; psel && !penable && paddr > 8'h10 |=> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
  property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_irq_excl; !(irq_high && irq_low); endproperty
  a_irq_excl: assert property (p_irq_excl) else $error("both priorities active");
  property p_irq_split; (irq_high || irq_low) == irq; endproperty
  a_irq_split: assert property (p_irq_split) else $error("priority outputs differ from irq");
  // Flag only clears by a write, so irq holds while the bus is idle
  property p_irq_hold; irq && !psel && !$past(psel) |=> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
  c_high: cover property (irq_high);
  c_low: cover property (irq_low);
  c_err: cover property (pslverr);
endmodule : tmrov_sva
bind tmrov_top tmrov_sva #(.ADDR_W(ADDR_W)) u_tmrov_sva (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .external_count_input, .irq,
  .irq_high, .irq_low);
`default_nettype wire

// ==== tmrov_pin_src.sv ====
`timescale 1ns/1ns
`default_nettype none
module tmrov_pin_src (
  // Clock
  input wire logic pclk,
  // Count pin
  output logic pin
);
  initial pin = 1'b0;
  // Waits out the write hold-off; pulses are 3 cycles high and low
  task automatic burst(input int n);
    repeat (12) @(posedge pclk);
    repeat (n) begin
      pin <= 1'b1;
      repeat (3) @(posedge pclk);
      pin <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask : burst
  // Leaves the pin at one level long enough to pass the synchroniser
  task automatic hold(input logic v);
    pin <= v;
    repeat (6) @(posedge pclk);
  endtask : hold
endmodule : tmrov_pin_src
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "tmrov_consts.svh"
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, pin, irq, irq_high, irq_low, e, p;
  logic [7:0] h;
  logic [2:0] ps_sel;
  logic [7:0] ps_steps;
  int seed = 32'hC7C5046F, fail_count = 0, n_compared = 0;
  initial forever #5 pclk = ~pclk;
  tmrov_top u_tmrov_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .external_count_input(pin), .irq, .irq_high, .irq_low);
  tmrov_pin_src u_tmrov_pin_src (.pclk, .pin);
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Read lands between two steps whatever the tick phase at the write
  function automatic int presc_wait(input logic [2:0] ratio_sel, input logic [7:0] steps);
    return 2 * `TMROV_INSTR_CYCLES + `TMROV_INSTR_CYCLES * (2 << ratio_sel) * steps - 2;
  endfunction : presc_wait
  function automatic logic [7:0] pin_count(input int rises, input int falls, input logic falling);
    return falling ? 8'(falls) : 8'(rises);
  endfunction : pin_count
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk("read", r, {24'h0, x});
  endtask : rd
  task automatic wait_irq;
    int i;
    for (i = 0; i < 3000 && irq !== 1'b1; i++) begin
      @(posedge pclk);
    end
    if (irq !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask : wait_irq
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 8'hC8);
    rd(8'h0C, 8'h00);
    rd(8'h10, 8'h00);
    apb(1'b0, 8'h14, 8'h00);
    chk("unmapped error", e, 1);
    chk("unmapped data", r, 0);
    h = 8'($random(seed));
    p = 1'($random(seed));
    apb(1'b1, 8'h10, {5'h00, p, 2'h0});
    apb(1'b1, 8'h0C, 8'h20);
    apb(1'b1, 8'h04, 8'hFE);
    rd(8'h04, 8'hFE);
    wait_irq();
    @(posedge pclk);
    chk("prio", {irq_high, irq_low}, {p, ~p});
    rd(8'h0C, 8'h24);
    apb(1'b1, 8'h0C, 8'h24);
    rd(8'h0C, 8'h20);
    chk("irq", irq, 0);
    apb(1'b1, 8'h00, 8'h88);
    apb(1'b1, 8'h08, h);
    apb(1'b1, 8'h04, 8'h10);
    apb(1'b1, 8'h08, ~h);
    rd(8'h04, 8'h10);
    rd(8'h08, h);
    apb(1'b1, 8'h08, 8'hFF);
    apb(1'b1, 8'h04, 8'hFE);
    wait_irq();
    rd(8'h0C, 8'h24);
    apb(1'b0, 8'h04, 8'h00);
    rd(8'h08, 8'h00);
    ps_sel = 3'($random(seed));
    ps_steps = 8'(1 + 2'($random(seed)));
    apb(1'b1, 8'h00, {5'h18, ps_sel});
    apb(1'b1, 8'h04, 8'h00);
    repeat (presc_wait(ps_sel, ps_steps)) @(posedge pclk);
    rd(8'h04, ps_steps);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 8'h00, k ? 8'hF8 : 8'hE8);
      apb(1'b1, 8'h04, 8'h00);
      u_tmrov_pin_src.burst(3);
      u_tmrov_pin_src.hold(1'b1);
      rd(8'h04, pin_count(4, 3, 1'(k)));
      u_tmrov_pin_src.hold(1'b0);
    end
    stop_test();
  end
endmodule : testbench
`default_nettype wire
